// [dv/cmp_skip_sva.sv]
`timescale 1ns/10ps
module cmp_skip_sva (
    input wire clk_sys_i,
    input wire rst_i,
    input wire carry_i,
    input wire [1:0] q_phase_o,
    input wire busy_o,
    input wire data_rd_o,
    input wire acc_rd_o,
    input wire acc_wr_o,
    input wire carry_wr_o,
    input wire carry_o,
    input wire skip_o,
    input wire discard_o,
    input wire done_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_idle4;
        (skip_o && !data_rd_o && !acc_rd_o && !acc_wr_o) [*4];
    endsequence
    property p_rd_q2; data_rd_o |-> q_phase_o == 2'h1 && busy_o; endproperty
    a_rd_q2: assert property (p_rd_q2) else $error("read off q2");
    property p_rd_once; data_rd_o |=> !data_rd_o [*3]; endproperty
    a_rd_once: assert property (p_rd_once) else $error("read twice");
    property p_no_wr; data_rd_o |=> (!acc_wr_o && !carry_wr_o) [*3]; endproperty
    a_no_wr: assert property (p_no_wr) else $error("compare wrote");
    property p_disc; discard_o |-> q_phase_o == 2'h3 && skip_o && $past(data_rd_o, 2); endproperty
    a_disc: assert property (p_disc) else $error("discard timing");
    property p_skip; discard_o |=> s_idle4 ##1 (done_o or (s_idle4 ##1 done_o)); endproperty
    a_skip: assert property (p_skip) else $error("skip length");
    property p_noskip; data_rd_o ##2 !discard_o |=> done_o; endproperty
    a_noskip: assert property (p_noskip) else $error("no skip length");
    property p_adjust;
        acc_rd_o |-> ##2 acc_wr_o && carry_wr_o && q_phase_o == 2'h3 ##1 done_o;
    endproperty
    a_adjust: assert property (p_adjust) else $error("adjust timing");
    property p_carry; acc_wr_o && $past(carry_i) |-> carry_o; endproperty
    a_carry: assert property (p_carry) else $error("carry lost");
endmodule // cmp_skip_sva
bind compare_skip_decimal_adjust cmp_skip_sva cmp_skip_sva_inst (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .carry_i(carry_i),
    .q_phase_o(q_phase_o),
    .busy_o(busy_o),
    .data_rd_o(data_rd_o),
    .acc_rd_o(acc_rd_o),
    .acc_wr_o(acc_wr_o),
    .carry_wr_o(carry_wr_o),
    .carry_o(carry_o),
    .skip_o(skip_o),
    .discard_o(discard_o),
    .done_o(done_o)
);

// [dv/test_compare_skip_decimal_adjust.sv]
`timescale 1ns/10ps
module test_compare_skip_decimal_adjust;
    reg clk_sys_i = 1'b0;
    reg rst_i = 1'b1;
    reg instr_valid_i = 1'b0;
    reg [15:0] instr_i = 16'h0000;
    reg next_two_word_i = 1'b0;
    reg [7:0] data_byte_i = 8'h00;
    reg [7:0] working_accumulator_i = 8'h00;
    reg [3:0] bank_select_pointer_i = 4'h0;
    reg half_carry_flag_i = 1'b0;
    reg carry_i = 1'b0;
    wire [1:0] q_phase_o;
    wire [11:0] data_addr_o;
    wire [7:0] acc_wdata_o;
    wire busy_o, data_rd_o, acc_rd_o, acc_wr_o, carry_wr_o, carry_o, skip_o, discard_o, done_o;
    integer err_total = 0;
    integer n_tests = 0;
    integer rd, disc_at, wr, dn, nw, n;
    reg [11:0] adr;
    always #20 clk_sys_i = ~clk_sys_i;
    compare_skip_decimal_adjust compare_skip_decimal_adjust_inst (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .instr_valid_i(instr_valid_i),
        .instr_i(instr_i),
        .next_two_word_i(next_two_word_i),
        .data_byte_i(data_byte_i),
        .working_accumulator_i(working_accumulator_i),
        .bank_select_pointer_i(bank_select_pointer_i),
        .half_carry_flag_i(half_carry_flag_i),
        .carry_i(carry_i),
        .q_phase_o(q_phase_o),
        .busy_o(busy_o),
        .data_rd_o(data_rd_o),
        .data_addr_o(data_addr_o),
        .acc_rd_o(acc_rd_o),
        .acc_wr_o(acc_wr_o),
        .acc_wdata_o(acc_wdata_o),
        .carry_wr_o(carry_wr_o),
        .carry_o(carry_o),
        .skip_o(skip_o),
        .discard_o(discard_o),
        .done_o(done_o)
    );
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // issue one instruction and log when data read, discard, acc write and done pulse, and count writes
    task issue(input [15:0] ins, input two);
        begin
            rd = 0;
            disc_at = 0;
            wr = 0;
            dn = 0;
            nw = 0;
            @(negedge clk_sys_i);
            while (q_phase_o !== 2'h3 || busy_o !== 1'b0) @(negedge clk_sys_i);
            @(posedge clk_sys_i);
            instr_valid_i <= 1'b1;
            instr_i <= ins;
            next_two_word_i <= two;
            @(posedge clk_sys_i);
            instr_valid_i <= 1'b0;
            for (n = 1; n < 15; n = n + 1) begin
                @(negedge clk_sys_i);
                if (data_rd_o === 1'b1) begin
                    rd = n;
                    adr = data_addr_o;
                end
                if (discard_o === 1'b1) disc_at = n;
                if (acc_wr_o === 1'b1) wr = n;
                if ((acc_wr_o | carry_wr_o) === 1'b1) nw = nw + 1;
                if (done_o === 1'b1 && dn == 0) dn = n;
            end
        end
    endtask
    task t_cmp(input [7:0] op, input [7:0] f, input [7:0] d, input [7:0] w, input two, input sk);
        begin
            @(posedge clk_sys_i);
            data_byte_i <= d;
            working_accumulator_i <= w;
            bank_select_pointer_i <= 4'ha;
            issue({op, f}, two);
            chk(rd, 1);
            chk(adr, {op[0] ? 4'ha : 4'h0, f});
            chk(disc_at, sk ? 3 : 0);
            chk(nw, 0);
            chk(dn, sk ? (two ? 12 : 8) : 4);
        end
    endtask
    task t_adjust(input [7:0] w, input hc, input c, input [7:0] r, input co);
        begin
            @(posedge clk_sys_i);
            working_accumulator_i <= w;
            half_carry_flag_i <= hc;
            carry_i <= c;
            issue(16'h0007, 1'b0);
            chk(wr, 3);
            chk(dn, 4);
            chk(acc_wdata_o, r);
            chk(carry_o, co);
        end
    endtask
    task t_other;
        begin
            issue(16'h6a12, 1'b0);
            chk(dn + rd + nw, 0);
        end
    endtask
    task print_verdict;
        begin
            $display("errors %0d checks %0d", err_total, n_tests);
            if (err_total == 0 && n_tests > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_cmp(8'h63, 8'h21, 8'h55, 8'h55, 1'b0, 1'b1);
        t_cmp(8'h62, 8'h22, 8'h54, 8'h55, 1'b1, 1'b0);
        t_cmp(8'h65, 8'h33, 8'h80, 8'h7f, 1'b1, 1'b1);
        t_cmp(8'h64, 8'h34, 8'h7f, 8'h80, 1'b0, 1'b0);
        t_cmp(8'h64, 8'hff, 8'h40, 8'h40, 1'b0, 1'b0);
        t_cmp(8'h60, 8'h00, 8'h00, 8'hff, 1'b1, 1'b1);
        t_cmp(8'h61, 8'h45, 8'hff, 8'h00, 1'b0, 1'b0);
        t_adjust(8'ha5, 1'b0, 1'b0, 8'h05, 1'b1);
        t_adjust(8'h12, 1'b1, 1'b0, 8'h18, 1'b0);
        t_adjust(8'h45, 1'b0, 1'b1, 8'ha5, 1'b1);
        t_other;
        print_verdict;
    end
    initial begin
        #100000;
        err_total = err_total + 1;
        print_verdict;
    end
endmodule // test_compare_skip_decimal_adjust

// [src/cmp_skip_regs.vh]
`ifndef CMP_SKIP_REGS_VH
`define CMP_SKIP_REGS_VH
`define OP_CMP_HI 8'h62
`define OP_CMP_LO 8'h60
`define OP_CMP_GT 8'h64
`define OP_CMP_MASK 8'hfe
`define OP_DEC_ADJ 16'h0007
`define NIB_LIMIT 4'h9
`define NIB_FIX 4'h6
`define Q_DECODE 2'h0
`define Q_READ 2'h1
`define Q_PROC 2'h2
`define Q_WRITE 2'h3
`define Q_LAST 2'h3
`define ACCESS_BANK 4'h0
`endif

// [src/compare_skip_decimal_adjust.v]
// Function
// - opcode 0110 001a compares equal, skip when byte equals accumulator.
// - opcode 0110 010a compares greater, skip when byte above accumulator unsigned.
// - opcode 0110 000a compares less, skip when byte below accumulator unsigned.
// - compares use unsigned subtraction and alter no flag, byte or accumulator.
// - true compare discards fetched next instruction, runs a nop, two cycles.
// - skipping a two-word instruction makes the compare three cycles.
// - skipped cycles idle in all four phases; two idle cycles for two-word.
// - normal compare cycle: decode, read byte, process, no write.
// - bit a low picks access bank, high picks bank select pointer bank.
// - opcode 0007 is decimal adjust: one cycle, read q2, write q4.
// - add six to low nibble when above nine or half carry set.
// - add six to high nibble when above nine or carry set; only carry changes.
`timescale 1ns/10ps
`include "cmp_skip_regs.vh"
module compare_skip_decimal_adjust (
    input wire clk_sys_i,
    input wire rst_i,
    input wire instr_valid_i,
    input wire [15:0] instr_i,
    input wire next_two_word_i,
    input wire [7:0] data_byte_i,
    input wire [7:0] working_accumulator_i,
    input wire [3:0] bank_select_pointer_i,
    input wire half_carry_flag_i,
    input wire carry_i,
    output reg [1:0] q_phase_o,
    output reg busy_o,
    output reg data_rd_o,
    output reg [11:0] data_addr_o,
    output reg acc_rd_o,
    output reg acc_wr_o,
    output reg [7:0] acc_wdata_o,
    output reg carry_wr_o,
    output reg carry_o,
    output reg skip_o,
    output reg discard_o,
    output reg done_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_CMP = 2'h1;
    localparam ST_ADJ = 2'h2;
    localparam ST_SKIP = 2'h3;
    localparam K_EQ = 2'h0;
    localparam K_GT = 2'h1;
    localparam K_LT = 2'h2;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [1:0] kind;
    reg [1:0] q;
    reg [1:0] skip_left;
    reg [7:0] f_addr;
    reg bank_a;
    reg [7:0] acc_lat;
    reg [7:0] byte_lat;
    reg take;
    wire [7:0] hi_op;
    wire is_cmp;
    wire is_adj;
    wire [8:0] diff;
    wire [7:0] adj_res;
    wire adj_carry;

    assign hi_op = instr_i[15:8];
    assign is_cmp = ((hi_op & `OP_CMP_MASK) == `OP_CMP_HI) ||
                    ((hi_op & `OP_CMP_MASK) == `OP_CMP_GT) ||
                    ((hi_op & `OP_CMP_MASK) == `OP_CMP_LO);
    assign is_adj = (instr_i == `OP_DEC_ADJ);
    // borrow and zero of byte minus accumulator, nothing stored
    assign diff = {1'b0, byte_lat} - {1'b0, acc_lat};

    decimal_adjust_unit decimal_adjust_unit_inst (
        .acc_i(acc_lat),
        .half_carry_i(half_carry_flag_i),
        .carry_i(carry_i),
        .result_o(adj_res),
        .carry_o(adj_carry)
    );

    always @* begin
        case (kind)
            K_EQ: take = (diff[7:0] == 8'h00);
            K_GT: take = !diff[8] && (diff[7:0] != 8'h00);
            K_LT: take = diff[8];
            default: take = 1'b0;
        endcase
    end

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (instr_valid_i && q == `Q_DECODE) begin
                    if (is_cmp) begin
                        next_state = ST_CMP;
                    end else if (is_adj) begin
                        next_state = ST_ADJ;
                    end
                end
            end
            ST_CMP: begin
                if (q == `Q_LAST) begin
                    next_state = take ? ST_SKIP : ST_IDLE;
                end
            end
            ST_ADJ: begin
                if (q == `Q_LAST) begin
                    next_state = ST_IDLE;
                end
            end
            ST_SKIP: begin
                if (q == `Q_LAST && skip_left == 2'h1) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            kind <= K_EQ;
            q <= `Q_DECODE;
            skip_left <= 2'h0;
            f_addr <= 8'h00;
            bank_a <= 1'b0;
            acc_lat <= 8'h00;
            byte_lat <= 8'h00;
            q_phase_o <= `Q_DECODE;
            busy_o <= 1'b0;
            data_rd_o <= 1'b0;
            data_addr_o <= 12'h000;
            acc_rd_o <= 1'b0;
            acc_wr_o <= 1'b0;
            acc_wdata_o <= 8'h00;
            carry_wr_o <= 1'b0;
            carry_o <= 1'b0;
            skip_o <= 1'b0;
            discard_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            state <= next_state;
            q <= q + 2'h1;
            q_phase_o <= q + 2'h1;
            busy_o <= (next_state != ST_IDLE);
            data_rd_o <= 1'b0;
            acc_rd_o <= 1'b0;
            acc_wr_o <= 1'b0;
            carry_wr_o <= 1'b0;
            discard_o <= 1'b0;
            done_o <= 1'b0;
            if (state == ST_IDLE && next_state != ST_IDLE) begin
                // q1 decode
                f_addr <= instr_i[7:0];
                bank_a <= instr_i[8];
                if ((hi_op & `OP_CMP_MASK) == `OP_CMP_HI) begin
                    kind <= K_EQ;
                end else if ((hi_op & `OP_CMP_MASK) == `OP_CMP_GT) begin
                    kind <= K_GT;
                end else begin
                    kind <= K_LT;
                end
                skip_left <= next_two_word_i ? 2'h2 : 2'h1;
                if (next_state == ST_CMP) begin
                    data_rd_o <= 1'b1;
                    data_addr_o <= {(instr_i[8] ? bank_select_pointer_i : `ACCESS_BANK),
                                    instr_i[7:0]};
                end else begin
                    acc_rd_o <= 1'b1;
                end
            end
            if (state == ST_CMP && q == `Q_READ) begin
                byte_lat <= data_byte_i;
                acc_lat <= working_accumulator_i;
            end
            if (state == ST_ADJ && q == `Q_READ) begin
                acc_lat <= working_accumulator_i;
            end
            if (state == ST_ADJ && q == `Q_PROC) begin
                acc_wr_o <= 1'b1;
                acc_wdata_o <= adj_res;
                carry_wr_o <= 1'b1;
                carry_o <= adj_carry;
            end
            if (state == ST_CMP && q == `Q_PROC) begin
                skip_o <= take;
                discard_o <= take;
            end
            if (state == ST_SKIP && q == `Q_LAST) begin
                // whole skipped cycle idles in every phase
                skip_left <= skip_left - 2'h1;
            end
            if (next_state == ST_IDLE && state != ST_IDLE && q == `Q_LAST) begin
                done_o <= 1'b1;
                skip_o <= 1'b0;
            end
        end
    end
endmodule // compare_skip_decimal_adjust

// [src/daw_unit.v]
`timescale 1ns/10ps
`include "cmp_skip_regs.vh"
module decimal_adjust_unit (
    input wire [7:0] acc_i,
    input wire half_carry_i,
    input wire carry_i,
    output reg [7:0] result_o,
    output reg carry_o
);
    reg [4:0] lo;
    reg [4:0] hi;
    always @* begin
        lo = {1'b0, acc_i[3:0]};
        hi = {1'b0, acc_i[7:4]};
        // low nibble correction
        if (acc_i[3:0] > `NIB_LIMIT || half_carry_i) begin
            lo = {1'b0, acc_i[3:0]} + {1'b0, `NIB_FIX};
        end
        // high nibble correction
        if (acc_i[7:4] > `NIB_LIMIT || carry_i) begin
            hi = {1'b0, acc_i[7:4]} + {1'b0, `NIB_FIX};
        end
        result_o = {hi[3:0], lo[3:0]};
        carry_o = carry_i | hi[4];
    end
endmodule // decimal_adjust_unit
